//--- core/pwr_ctrl_params.svh
// Constants for the power mode and clock output controller.
`ifndef PWR_CTRL_PARAMS_SVH
`define PWR_CTRL_PARAMS_SVH
`define LP_SEL_STOP 3'h1
`define LP_SEL_SLEEP 3'h2
`define LP_SEL_IDLE 3'h3
`define CKO_SEL_SLOW 2'h0
`define CKO_SEL_HALF 2'h1
`define CKO_SEL_SYS 2'h2
`define CKO_SEL_PRESC 2'h3
`define WARMUP_W 20
`define WARMUP_DEFAULT 20'h00400
`endif

//--- core/pwr_ctrl_pkg.sv
// Types for the power mode and clock output controller.
package pwr_ctrl_pkg;
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_SLOW = 5'h02,
    ST_IDLE = 5'h04,
    ST_SLEEP = 5'h08,
    ST_STOP = 5'h10
  } pmode_t;
endpackage : pwr_ctrl_pkg

//--- core/pwr_link_if.sv
// Interface between the power controller and the core side that requests modes.
`timescale 1ns/1ns
`default_nettype none
interface pwr_link_if;
  logic [2:0] lp_sel;
  logic run_slow_req;
  logic wait_for_interrupt_instr;
  logic wait_for_event_instr;
  logic core_deep_sleep_bit;
  logic core_system_reset_request;
  logic wake_irq;
  logic [1:0] clk_out_sel;
  logic drive_en;
  logic core_halt;
  logic [4:0] mode;
  logic warmup_busy;
  modport dev (
    input lp_sel, run_slow_req, wait_for_interrupt_instr, wait_for_event_instr, core_deep_sleep_bit,
    input core_system_reset_request, wake_irq, clk_out_sel, drive_en,
    output core_halt, mode, warmup_busy
  );
  modport host (
    output lp_sel, run_slow_req, wait_for_interrupt_instr, wait_for_event_instr, core_deep_sleep_bit,
    output core_system_reset_request, wake_irq, clk_out_sel, drive_en,
    input core_halt, mode, warmup_busy
  );
endinterface : pwr_link_if
`default_nettype wire

//--- core/pwr_mode_ctrl.sv
// Device end: mode state machine, clock gating, warm-up and clock output mux.
// Behaviour
// - Output mux: slow, half, system, prescaler clock.
// - Prescaler clock output static in low-power modes.
// - Software sets port-K control and function bits.
// - NORMAL uses fast clock, SLOW uses slow.
// - IDLE, SLEEP and STOP halt the core.
// - No SLOW or SLEEP without slow clock.
// - Reset always starts in NORMAL mode.
// - SLOW stops fast clock, few units clocked.
// - Stop other peripherals before entering SLOW.
// - No core system reset while in SLOW.
// - Select field then wait instruction enters mode.
// - Reset or enabled interrupt leaves low-power mode.
// - Never enter low power by wait-for-event.
// - Keep the core deep-sleep bit cleared.
// - IDLE stops CPU; disabled peripherals freeze.
// - SLEEP keeps slow oscillator, RTC, CEC, remote.
// - SLEEP release returns to previous run mode.
// - STOP halts all circuits and oscillators.
// - STOP release returns to previous run mode.
// - STOP pins off unless drive bit set.
// - Unused debug pin set to general port.
// - Select codes: STOP 001, SLEEP 010, IDLE 011.
// - Auto warm-up after STOP or SLEEP to NORMAL.
`include "pwr_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pwr_mode_ctrl #(
  parameter logic [`WARMUP_W-1:0] WARMUP_CYCLES = `WARMUP_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  pwr_link_if.dev link,
  input wire logic low_speed_clock,
  input wire logic prescaler_input_clock,
  input wire logic portk_bit1_output_ctrl,
  input wire logic portk_bit1_function_sel,
  input wire logic [7:0] periph_idle_en,
  input wire logic port_input_enable,
  input wire logic port_output_control,
  output logic clock_out_pin,
  output logic clock_out_oe,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic sys_clk_from_slow,
  output logic [7:0] periph_clk_en,
  output logic aon_clk_en,
  output logic port_in_en,
  output logic port_out_en
);
  pwr_ctrl_pkg::pmode_t state_r;
  pwr_ctrl_pkg::pmode_t state_nxt;
  pwr_ctrl_pkg::pmode_t ret_r;
  logic [`WARMUP_W-1:0] wu_cnt_r;
  logic half_r;
  logic slow_s1_r;
  logic slow_s2_r;
  logic presc_s1_r;
  logic presc_s2_r;
  logic presc_hold_r;
  logic cko_r;
  logic div_r;
  logic wu_done_r;

  wire logic in_low = (state_r == pwr_ctrl_pkg::ST_IDLE) || (state_r == pwr_ctrl_pkg::ST_SLEEP)
                      || (state_r == pwr_ctrl_pkg::ST_STOP);
  wire logic warm = (wu_cnt_r != '0);
  wire logic enter = link.wait_for_interrupt_instr && !link.wait_for_event_instr
                     && !link.core_deep_sleep_bit;
  wire logic sel_stop = (link.lp_sel == `LP_SEL_STOP);
  wire logic sel_sleep = (link.lp_sel == `LP_SEL_SLEEP);
  wire logic sel_idle = (link.lp_sel == `LP_SEL_IDLE);
  wire logic ret_normal = (ret_r == pwr_ctrl_pkg::ST_NORMAL);
  // Only a wake from STOP, or from SLEEP back to NORMAL, waits for the warm-up count.
  wire logic need_warm = ((state_r == pwr_ctrl_pkg::ST_STOP)
                          || (state_r == pwr_ctrl_pkg::ST_SLEEP && ret_normal))
                         && (WARMUP_CYCLES != '0);
  wire logic last_tick = warm && (wu_cnt_r[`WARMUP_W-1:1] == '0);
  wire logic warm_start = link.wake_irq && need_warm
                          && !warm && !wu_done_r;
  wire logic leave_ok = link.wake_irq && !warm && (!need_warm || wu_done_r);

  // Run modes take a wait instruction; low-power modes leave only on a wake request.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pwr_ctrl_pkg::ST_NORMAL: begin
        if (enter && sel_stop) begin
          state_nxt = pwr_ctrl_pkg::ST_STOP;
        end else if (enter && sel_sleep) begin
          state_nxt = pwr_ctrl_pkg::ST_SLEEP;
        end else if (enter && sel_idle) begin
          state_nxt = pwr_ctrl_pkg::ST_IDLE;
        end else if (link.run_slow_req) begin
          state_nxt = pwr_ctrl_pkg::ST_SLOW;
        end
      end
      pwr_ctrl_pkg::ST_SLOW: begin
        if (enter && sel_stop) begin
          state_nxt = pwr_ctrl_pkg::ST_STOP;
        end else if (enter && sel_sleep) begin
          state_nxt = pwr_ctrl_pkg::ST_SLEEP;
        end else if (enter && sel_idle) begin
          state_nxt = pwr_ctrl_pkg::ST_IDLE;
        end else if (!link.run_slow_req) begin
          state_nxt = pwr_ctrl_pkg::ST_NORMAL;
        end
      end
      pwr_ctrl_pkg::ST_IDLE, pwr_ctrl_pkg::ST_SLEEP, pwr_ctrl_pkg::ST_STOP: begin
        if (leave_ok) begin
          state_nxt = ret_r;
        end
      end
      default: begin
        state_nxt = pwr_ctrl_pkg::ST_NORMAL;
      end
    endcase
  end

  // The mode is taken once at entry; later select writes have no effect until release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pwr_ctrl_pkg::ST_NORMAL;
      ret_r <= pwr_ctrl_pkg::ST_NORMAL;
    end else begin
      state_r <= state_nxt;
      // The run mode in force at entry is where a wake returns.
      if (!in_low && state_nxt != state_r && state_nxt != pwr_ctrl_pkg::ST_NORMAL
          && state_nxt != pwr_ctrl_pkg::ST_SLOW) begin
        ret_r <= state_r;
      end
    end
  end

  // Warm-up runs on wake from STOP, or from SLEEP back to NORMAL, before the clock resumes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wu_cnt_r <= '0;
    end else if (warm) begin
      wu_cnt_r <= wu_cnt_r - 1'b1;
    end else if (warm_start) begin
      wu_cnt_r <= WARMUP_CYCLES;
    end
  end

  // Remembers a finished warm-up until the mode is left, so the count runs once per wake.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wu_done_r <= 1'b0;
    end else if (!in_low) begin
      wu_done_r <= 1'b0;
    end else if (last_tick) begin
      wu_done_r <= 1'b1;
    end
  end

  // Clock and port enables follow the mode; a running warm-up keeps its oscillator on.
  assign link.mode = state_r;
  assign link.warmup_busy = warm;
  assign link.core_halt = in_low || warm;
  assign fast_osc_en = (state_r == pwr_ctrl_pkg::ST_NORMAL) || (state_r == pwr_ctrl_pkg::ST_IDLE)
                       || (warm && ret_normal);
  assign slow_osc_en = (state_r != pwr_ctrl_pkg::ST_STOP) || warm;
  assign sys_clk_from_slow = (state_r == pwr_ctrl_pkg::ST_SLOW)
                             || (in_low && !ret_normal);
  assign periph_clk_en = (state_r == pwr_ctrl_pkg::ST_NORMAL) ? 8'hff :
                         (state_r == pwr_ctrl_pkg::ST_IDLE) ? periph_idle_en : 8'h00;
  assign aon_clk_en = (state_r != pwr_ctrl_pkg::ST_STOP);
  assign port_in_en = (state_r != pwr_ctrl_pkg::ST_STOP) || (link.drive_en && port_input_enable);
  assign port_out_en = (state_r != pwr_ctrl_pkg::ST_STOP) || (link.drive_en && port_output_control);

  // Pin-sourced clocks pass two flip-flops before use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 1'b0;
      div_r <= 1'b0;
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      presc_s1_r <= 1'b0;
      presc_s2_r <= 1'b0;
      presc_hold_r <= 1'b0;
      cko_r <= 1'b0;
    end else begin
      // The half-rate output toggles on every second edge.
      div_r <= ~div_r;
      half_r <= half_r ^ div_r;
      slow_s1_r <= low_speed_clock;
      slow_s2_r <= slow_s1_r;
      presc_s1_r <= prescaler_input_clock;
      presc_s2_r <= presc_s1_r;
      if (!in_low) begin
        presc_hold_r <= presc_s2_r;
      end
      case (link.clk_out_sel)
        `CKO_SEL_SLOW: cko_r <= slow_s2_r;
        `CKO_SEL_HALF: cko_r <= half_r;
        `CKO_SEL_SYS: cko_r <= ~cko_r;
        default: cko_r <= presc_hold_r;
      endcase
    end
  end

  assign clock_out_pin = cko_r;
  assign clock_out_oe = portk_bit1_output_ctrl && portk_bit1_function_sel;
endmodule : pwr_mode_ctrl
`default_nettype wire

//--- core/pwr_core_side.sv
// Core end: drives mode requests and keeps software-side constraints.
`include "pwr_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pwr_core_side (
  input wire logic clk,
  input wire logic rst_n,
  pwr_link_if.host link,
  input wire logic [2:0] user_lp_sel,
  input wire logic user_slow,
  input wire logic user_wfi,
  input wire logic user_sys_reset,
  input wire logic user_irq,
  input wire logic [1:0] user_clk_out_sel,
  input wire logic user_drive_en,
  input wire logic slow_clock_in_use,
  output logic halted,
  output logic [4:0] mode_seen
);
  logic [2:0] sel_r;
  logic slow_r;
  logic wfi_r;
  logic rst_req_r;
  wire logic sel_ok = (user_lp_sel == `LP_SEL_STOP) || (user_lp_sel == `LP_SEL_IDLE)
                      || ((user_lp_sel == `LP_SEL_SLEEP) && slow_clock_in_use);
  wire logic in_slow = (link.mode == pwr_ctrl_pkg::ST_SLOW);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= `LP_SEL_IDLE;
      slow_r <= 1'b0;
      wfi_r <= 1'b0;
      rst_req_r <= 1'b0;
    end else begin
      if (sel_ok && !link.core_halt) begin
        sel_r <= user_lp_sel;
      end
      slow_r <= user_slow && slow_clock_in_use;
      wfi_r <= user_wfi && !link.core_halt && !wfi_r;
      rst_req_r <= user_sys_reset && !in_slow;
    end
  end

  assign link.lp_sel = sel_r;
  assign link.run_slow_req = slow_r;
  assign link.wait_for_interrupt_instr = wfi_r;
  assign link.wait_for_event_instr = 1'b0;
  assign link.core_deep_sleep_bit = 1'b0;
  assign link.core_system_reset_request = rst_req_r;
  assign link.wake_irq = user_irq;
  assign link.clk_out_sel = user_clk_out_sel;
  assign link.drive_en = user_drive_en;
  assign halted = link.core_halt;
  assign mode_seen = link.mode;
endmodule : pwr_core_side
`default_nettype wire

//--- bench/pwr_link_sva.sv
// Assertions on the link between the power controller and the core side.
`timescale 1ns/1ns
`default_nettype none
module pwr_link_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] lp_sel,
  input wire logic wait_for_interrupt_instr,
  input wire logic wait_for_event_instr,
  input wire logic core_deep_sleep_bit,
  input wire logic wake_irq,
  input wire logic core_halt,
  input wire logic [4:0] mode,
  input wire logic warmup_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic run_w;
  wire logic take_w;
  assign run_w = mode == 5'h01 || mode == 5'h02;
  assign take_w = wait_for_interrupt_instr && run_w && !wait_for_event_instr && !core_deep_sleep_bit;
  idle_entry_a: assert property (take_w && lp_sel == 3'h3 |=> mode == 5'h04) else $error("idle not entered");
  sleep_entry_a: assert property (take_w && lp_sel == 3'h2 |=> mode == 5'h08) else $error("sleep not entered");
  stop_entry_a: assert property (take_w && lp_sel == 3'h1 |=> mode == 5'h10) else $error("stop not entered");
  bad_code_a: assert property (take_w && !(lp_sel inside {3'h1, 3'h2, 3'h3}) |=> run_w)
    else $error("bad code entered low power");
  event_block_a: assert property (wait_for_interrupt_instr && run_w && wait_for_event_instr |=> run_w)
    else $error("entered on event wait");
  halt_low_a: assert property (!run_w |-> core_halt) else $error("core runs in low power");
  run_free_a: assert property (run_w |-> !core_halt) else $error("core halted in run mode");
  sel_ignore_a: assert property (mode == 5'h04 && !wake_irq |=> mode == 5'h04) else $error("idle left early");
  idle_wake_a: assert property (mode == 5'h04 && wake_irq |=> run_w) else $error("idle wake late");
  warm_halt_a: assert property (warmup_busy |-> core_halt && (mode == 5'h08 || mode == 5'h10))
    else $error("warm-up outside sleep or stop");
  stop_wake_a: assert property (mode == 5'h10 && wake_irq |-> ##[1:16] run_w) else $error("stop wake late");
  reset_normal_a: assert property ($rose(rst_n) |-> mode == 5'h01) else $error("reset mode wrong");
  cover property (mode == 5'h04);
  cover property (mode == 5'h08);
  cover property (mode == 5'h10);
  cover property ($fell(warmup_busy));
endmodule : pwr_link_sva
`default_nettype wire

//--- bench/power_mode_and_clock_out_ctrl_bench.sv
// Testbench joining the device end and the core end of the power link.
`timescale 1ns/1ns
`default_nettype none
module power_mode_and_clock_out_ctrl_bench;
  int fail_count;
  int comparisons;
  int cycles;
  logic clk, rst_n, slow_clk, presc_clk, pk_ctrl, pk_func, pin_ie, pin_oc;
  logic u_slow, u_wfi, u_rst, u_irq, u_drv, u_use;
  logic [2:0] u_sel;
  logic [1:0] u_cko;
  logic [7:0] idle_en, pclk_en;
  logic halted, cko, cko_oe, fast_en, slow_en, from_slow, aon_en, p_in, p_out, ref_v;
  logic [4:0] mode_seen;
  pwr_link_if link ();
  pwr_mode_ctrl #(.WARMUP_CYCLES(20'h00008)) pwr_mode_ctrl_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .low_speed_clock(slow_clk), .prescaler_input_clock(presc_clk), .portk_bit1_output_ctrl(pk_ctrl),
    .portk_bit1_function_sel(pk_func), .periph_idle_en(idle_en), .port_input_enable(pin_ie),
    .port_output_control(pin_oc), .clock_out_pin(cko), .clock_out_oe(cko_oe), .fast_osc_en(fast_en),
    .slow_osc_en(slow_en), .sys_clk_from_slow(from_slow), .periph_clk_en(pclk_en), .aon_clk_en(aon_en),
    .port_in_en(p_in), .port_out_en(p_out));
  pwr_core_side pwr_core_side_inst (.clk(clk), .rst_n(rst_n), .link(link), .user_lp_sel(u_sel),
    .user_slow(u_slow), .user_wfi(u_wfi), .user_sys_reset(u_rst), .user_irq(u_irq), .user_clk_out_sel(u_cko),
    .user_drive_en(u_drv), .slow_clock_in_use(u_use), .halted(halted), .mode_seen(mode_seen));
  pwr_link_sva pwr_link_sva_inst (.clk(clk), .rst_n(rst_n), .lp_sel(link.lp_sel),
    .wait_for_interrupt_instr(link.wait_for_interrupt_instr), .wait_for_event_instr(link.wait_for_event_instr),
    .core_deep_sleep_bit(link.core_deep_sleep_bit), .wake_irq(link.wake_irq), .core_halt(link.core_halt),
    .mode(link.mode), .warmup_busy(link.warmup_busy));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic enter(input logic [2:0] code, input logic drv);
    u_sel = code;
    u_drv = drv;
    u_wfi = 1'b1;
    @(negedge clk);
    u_wfi = 1'b0;
    repeat (6) if (halted !== 1'b1) @(negedge clk);
    u_sel = 3'h3;
  endtask : enter
  task automatic wake(input logic [4:0] ret, input logic warm);
    logic seen;
    seen = 1'b0;
    u_irq = 1'b1;
    repeat (24) if (halted !== 1'b0) begin
      @(negedge clk);
      if (link.warmup_busy === 1'b1) seen = 1'b1;
    end
    u_irq = 1'b0;
    chk(8'(mode_seen), 8'(ret));
    chk(8'(seen), 8'(warm));
    @(negedge clk);
  endtask : wake
  task automatic t_cko();
    pk_ctrl = 1'b1;
    @(negedge clk);
    chk(8'(cko_oe), 8'h00);
    pk_func = 1'b1;
    u_cko = 2'h2;
    repeat (4) @(negedge clk);
    chk(8'(cko_oe), 8'h01);
    ref_v = cko;
    @(negedge clk);
    chk(8'(cko), 8'({~ref_v}));
    u_cko = 2'h1;
    repeat (4) @(negedge clk);
    ref_v = cko;
    repeat (2) @(negedge clk);
    chk(8'(cko), 8'({~ref_v}));
    u_cko = 2'h0;
    repeat (4) @(negedge clk);
    ref_v = cko;
    repeat (4) @(negedge clk);
    chk(8'(cko), 8'({~ref_v}));
    u_cko = 2'h3;
    repeat (4) @(negedge clk);
    ref_v = cko;
    repeat (3) @(negedge clk);
    chk(8'(cko), 8'({~ref_v}));
    $display("clock out test done");
  endtask : t_cko
  task automatic t_idle();
    u_cko = 2'h3;
    enter(3'h3, 1'b0);
    chk(8'(mode_seen), 8'h04);
    chk(pclk_en, idle_en);
    @(negedge clk);
    ref_v = cko;
    repeat (8) @(negedge clk);
    chk(8'(cko), 8'(ref_v));
    wake(5'h01, 1'b0);
    $display("idle test done");
  endtask : t_idle
  task automatic t_sleep_stop();
    enter(3'h2, 1'b0);
    chk(8'(mode_seen), 8'h08);
    chk(8'({fast_en, slow_en, aon_en}), 8'h03);
    wake(5'h01, 1'b1);
    enter(3'h1, 1'b1);
    chk(8'(mode_seen), 8'h10);
    chk(8'({fast_en, slow_en, p_in, p_out}), 8'({2'b00, pin_ie, pin_oc}));
    wake(5'h01, 1'b1);
    enter(3'h1, 1'b0);
    chk(8'({p_in, p_out}), 8'h00);
    wake(5'h01, 1'b1);
    $display("sleep and stop test done");
  endtask : t_sleep_stop
  task automatic t_slow();
    u_slow = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'(mode_seen), 8'h02);
    chk(8'({fast_en, from_slow}), 8'h01);
    u_rst = 1'b1;
    @(negedge clk);
    chk(8'(link.core_system_reset_request), 8'h00);
    u_rst = 1'b0;
    enter(3'h1, 1'b1);
    wake(5'h02, 1'b1);
    u_slow = 1'b0;
    repeat (4) @(negedge clk);
    chk(8'(mode_seen), 8'h01);
    u_rst = 1'b1;
    @(negedge clk);
    chk(8'(link.core_system_reset_request), 8'h01);
    u_rst = 1'b0;
    u_use = 1'b0;
    u_slow = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'(mode_seen), 8'h01);
    u_slow = 1'b0;
    u_use = 1'b1;
    @(negedge clk);
    $display("slow test done");
  endtask : t_slow
  task automatic t_bad();
    for (int c = 4; c < 9; c++) begin
      enter(3'(c), 1'b0);
      chk(8'(mode_seen), 8'h04);
      wake(5'h01, 1'b0);
    end
    $display("bad code test done");
  endtask : t_bad
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    slow_clk = 1'b0;
    forever #160 slow_clk = ~slow_clk;
  end
  initial begin
    presc_clk = 1'b0;
    forever #120 presc_clk = ~presc_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {fail_count, comparisons, cycles} = '0;
    {rst_n, pk_ctrl, pk_func, u_slow, u_wfi, u_rst, u_irq, u_drv} = '0;
    {u_use, pin_ie, pin_oc} = 3'b111;
    u_sel = 3'h3;
    u_cko = 2'h0;
    idle_en = 8'ha5;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(8'(mode_seen), 8'h01);
    chk(pclk_en, 8'hff);
    t_cko();
    t_idle();
    t_sleep_stop();
    t_slow();
    t_bad();
    stop_test();
  end
endmodule : power_mode_and_clock_out_ctrl_bench
`default_nettype wire
